//--- include/wdt_defines.svh
// constants for the watchdog and interval timer channel
// assumes a 40 MHz system clock and a plain strobe register port
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define WDT_ADDR_W 3
`define WDT_ADDR_COUNTER 3'h0
`define WDT_ADDR_CTRL 3'h1
`define WDT_ADDR_KEY 3'h2
`define WDT_ADDR_IRQ_STATUS 3'h3
`define WDT_ADDR_IRQ_MASK 3'h4
`define WDT_KEY_DEFAULT 8'h5A
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_ENABLE 5
`define WDT_BIT_RESERVED 4
`define WDT_BIT_RST_NMI 3
`define WDT_CTRL_RESET 8'h00
`define WDT_CTRL_WMASK 8'h6F
`define WDT_PRESCALE_W 17
`define WDT_IRQ_NMI 0
`define WDT_IRQ_RESET 1
`define WDT_IRQ_INTERVAL 2
`endif

//--- include/wdt_pkg.sv
// types for the watchdog and interval timer channel
// assumes wdt_defines.svh for numeric constants
package wdt_pkg;
  typedef enum logic {
    WDT_KEY_IDLE,
    WDT_KEY_ARMED
  } wdt_key_state_t;

  typedef struct packed {
    logic [16:0] prescale;
    logic [7:0] counter;
    logic ovf;
    logic mode;
    logic enable;
    logic reserved;
    logic rst_nmi;
    logic [2:0] clk_sel;
    logic ovf_seen;
    wdt_key_state_t key_state;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] rd_data;
    logic reset_pulse;
    logic nmi_pulse;
    logic interval_pulse;
  } wdt_state_t;
endpackage : wdt_pkg

//--- verilog/wdt_timer.sv
// watchdog and interval timer channel with key-protected counter and control writes
// assumes one 40 MHz clock, a synchronous reset and a same-domain cpu port
//
// Local design decisions: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "wdt_defines.svh"

module wdt_timer #(
  parameter logic [7:0] KEY = `WDT_KEY_DEFAULT
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // register port
  input wire logic [`WDT_ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // overflow requests
  output logic sys_reset_req_out,
  output logic nmi_req_out,
  output logic interval_overflow_irq_out,
  output logic overflow_reset_n_out,
  // interrupt
  output logic irq_out
);

  wdt_pkg::wdt_state_t st;
  wdt_pkg::wdt_state_t next_st;

  logic tick;
  logic wrap;
  logic key_ok;
  logic wr_counter;
  logic wr_ctrl;
  logic [7:0] ctrl_view;

  // divided tick from the free prescaler
  always_comb begin
    unique case (st.clk_sel)
      3'h0: tick = st.prescale[0:0] == 1'h1;
      3'h1: tick = st.prescale[5:0] == 6'h3F;
      3'h2: tick = st.prescale[6:0] == 7'h7F;
      3'h3: tick = st.prescale[8:0] == 9'h1FF;
      3'h4: tick = st.prescale[10:0] == 11'h7FF;
      3'h5: tick = st.prescale[12:0] == 13'h1FFF;
      3'h6: tick = st.prescale[14:0] == 15'h7FFF;
      3'h7: tick = st.prescale[16:0] == 17'h1FFFF;
    endcase
  end

  assign ctrl_view = {st.ovf, st.mode, st.enable, st.reserved, st.rst_nmi, st.clk_sel};
  assign key_ok = st.key_state == wdt_pkg::WDT_KEY_ARMED;
  assign wr_counter = wr_en_in && addr_in == `WDT_ADDR_COUNTER && key_ok;
  assign wr_ctrl = wr_en_in && addr_in == `WDT_ADDR_CTRL && key_ok;
  assign wrap = st.enable && tick && st.counter == 8'hFF;

  always_comb begin
    next_st = st;
    next_st.reset_pulse = 1'b0;
    next_st.nmi_pulse = 1'b0;
    next_st.interval_pulse = 1'b0;
    next_st.prescale = st.prescale + 17'h00001;
    // key arms one following write
    if (wr_en_in && addr_in == `WDT_ADDR_KEY) begin
      next_st.key_state = (wr_data_in == KEY) ? wdt_pkg::WDT_KEY_ARMED
                                              : wdt_pkg::WDT_KEY_IDLE;
    end else if (wr_en_in) begin
      next_st.key_state = wdt_pkg::WDT_KEY_IDLE;
    end
    // read data and read-side effects
    next_st.rd_data = 8'h00;
    if (rd_en_in) begin
      unique case (addr_in)
        `WDT_ADDR_COUNTER: next_st.rd_data = st.counter;
        `WDT_ADDR_CTRL: begin
          next_st.rd_data = ctrl_view;
          if (st.ovf) next_st.ovf_seen = 1'b1;
        end
        `WDT_ADDR_KEY: next_st.rd_data = {7'h00, key_ok};
        `WDT_ADDR_IRQ_STATUS: begin
          next_st.rd_data = {5'h00, st.irq_status};
          next_st.irq_status = 3'h0;
        end
        `WDT_ADDR_IRQ_MASK: next_st.rd_data = {5'h00, st.irq_mask};
        default: next_st.rd_data = 8'h00;
      endcase
    end
    if (wr_en_in && addr_in == `WDT_ADDR_IRQ_MASK) begin
      next_st.irq_mask = wr_data_in[2:0];
    end
    // control register write
    if (wr_ctrl) begin
      next_st.mode = wr_data_in[`WDT_BIT_MODE];
      next_st.enable = wr_data_in[`WDT_BIT_ENABLE];
      next_st.reserved = wr_data_in[`WDT_BIT_RESERVED];
      next_st.rst_nmi = wr_data_in[`WDT_BIT_RST_NMI];
      next_st.clk_sel = wr_data_in[2:0];
      // a zero after a seen-set read clears, as does any write with enable low; otherwise the bit is ignored
      if (!wr_data_in[`WDT_BIT_OVF] && st.ovf_seen) begin
        next_st.ovf = 1'b0;
        next_st.ovf_seen = 1'b0;
      end
      if (!wr_data_in[`WDT_BIT_ENABLE]) begin
        next_st.ovf = 1'b0;
        next_st.ovf_seen = 1'b0;
      end
    end
    // counter
    if (!next_st.enable) begin
      next_st.counter = 8'h00;
    end else if (wr_counter) begin
      next_st.counter = wr_data_in;
    end else if (st.enable && tick) begin
      next_st.counter = st.counter + 8'h01;
    end
    // overflow event: set wins over clear
    if (wrap) begin
      next_st.ovf = 1'b1;
      next_st.ovf_seen = 1'b0;
      if (st.mode) begin
        if (st.rst_nmi) begin
          next_st.reset_pulse = 1'b1;
          next_st.irq_status[`WDT_IRQ_RESET] = 1'b1;
        end else begin
          next_st.nmi_pulse = 1'b1;
          next_st.irq_status[`WDT_IRQ_NMI] = 1'b1;
        end
      end else begin
        next_st.interval_pulse = 1'b1;
        next_st.irq_status[`WDT_IRQ_INTERVAL] = 1'b1;
      end
    end
    // internal reset clears the flag it caused
    if (st.reset_pulse) begin
      next_st.ovf = 1'b0;
      next_st.ovf_seen = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_out = st.rd_data;
  assign sys_reset_req_out = st.reset_pulse;
  assign nmi_req_out = st.nmi_pulse;
  assign interval_overflow_irq_out = st.interval_pulse;
  assign overflow_reset_n_out = ~st.reset_pulse;
  assign irq_out = |(st.irq_status & st.irq_mask);

endmodule : wdt_timer

//--- test/wdt_timer_chk.sv
// port checker for the timer channel
// bound into every wdt_timer instance
`timescale 1ns/1ps
module wdt_timer_chk (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [2:0] addr_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic sys_reset_req_out,
  input wire logic nmi_req_out,
  input wire logic interval_overflow_irq_out,
  input wire logic overflow_reset_n_out,
  input wire logic irq_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_pin; overflow_reset_n_out == !sys_reset_req_out; endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_rp; sys_reset_req_out |=> !sys_reset_req_out; endproperty
  a_rp: assert property (p_rp) else $error("rst");
  property p_np; nmi_req_out |=> !nmi_req_out; endproperty
  a_np: assert property (p_np) else $error("nmi");
  property p_ip; interval_overflow_irq_out |=> !interval_overflow_irq_out; endproperty
  a_ip: assert property (p_ip) else $error("int");
  property p_one;
    $onehot0({sys_reset_req_out, nmi_req_out, interval_overflow_irq_out});
  endproperty
  a_one: assert property (p_one) else $error("two");
  property p_idle; !rd_en_in |=> rd_data_out == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_unm; rd_en_in && addr_in > 3'h4 |=> rd_data_out == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unm");
  property p_irq;
    $rose(irq_out) |-> interval_overflow_irq_out || nmi_req_out
      || sys_reset_req_out || $past(wr_en_in);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  c_int: cover property (interval_overflow_irq_out);
  c_nmi: cover property (nmi_req_out);
  c_rst: cover property (sys_reset_req_out);
endmodule : wdt_timer_chk
bind wdt_timer wdt_timer_chk u_chk (.*);

//--- test/wdt_sys_model.sv
// request sink for reset, nmi and interrupt logic
// counts one-cycle request pulses
`timescale 1ns/1ps
module wdt_sys_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // requests: interval, nmi, reset
  input wire logic [2:0] req_in,
  output logic [2:0][7:0] cnt_out
);
  always_ff @(posedge sys_clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_in) begin
        cnt_out[i] <= 8'h00;
      end else if (req_in[i]) begin
        cnt_out[i] <= cnt_out[i] + 8'h01;
      end
    end
  end
endmodule : wdt_sys_model

//--- test/wdt_timer_tb.sv
// self-checking bench for the timer channel
// drives the register port, counts requests in the sink model
`timescale 1ns/1ps
module wdt_timer_tb;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] rd_data_out, v;
  logic sys_reset_req_out, nmi_req_out, interval_overflow_irq_out;
  logic overflow_reset_n_out, irq_out;
  logic [2:0][7:0] cnt;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  wdt_timer DUT (.*);
  wdt_sys_model u_sys (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cnt_out(cnt),
    .req_in({sys_reset_req_out, nmi_req_out, interval_overflow_irq_out}));
  initial begin
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    rd_en_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  task automatic kw(input logic [2:0] a, input logic [7:0] d);
    wr(3'h2, 8'h5A);
    wr(a, d);
  endtask : kw
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_en_in <= 1'b1;
    wr_en_in <= 1'b0;
    exp_q.push_back(e);
    @(posedge sys_clk_in);
  endtask : rd
  task automatic wait_ev(input int k);
    logic [7:0] c0;
    c0 = cnt[k];
    wr_en_in <= 1'b0;
    rd_en_in <= 1'b0;
    repeat (700) if (cnt[k] == c0) @(posedge sys_clk_in);
    chk("event", cnt[k], c0 + 8'h01);
  endtask : wait_ev
  always @(posedge sys_clk_in) begin
    rd_pend <= rd_en_in;
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  always @(negedge sys_clk_in) begin
    if (rd_pend) begin
      chk("rd_data", rd_data_out, exp_q.pop_front());
    end
  end
  initial begin
    void'($urandom(92));
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    rd(3'h1, 8'h00);
    rd(3'h7, 8'h00);
    wr(3'h1, 8'h20);
    rd(3'h1, 8'h00);
    wr(3'h4, 8'h07);
    kw(3'h1, 8'h20);
    wait_ev(0);
    chk("irq", {7'h00, irq_out}, 8'h01);
    kw(3'h1, 8'h20);
    rd(3'h1, 8'hA0);
    rd(3'h1, 8'hA0);
    kw(3'h1, 8'h20);
    rd(3'h1, 8'h20);
    kw(3'h1, 8'hA0);
    rd(3'h1, 8'h20);
    rd(3'h3, 8'h04);
    $display("interval done");
    for (int i = 1; i < 3; i++) begin
      v = 8'h60 | {4'h0, i[1], 3'h0};
      kw(3'h1, v);
      chk("irq_level", {7'h00, irq_out}, {7'h00, i[1]});
      kw(3'h0, 8'hF0 | 8'($urandom_range(15)));
      wait_ev(i);
      rd(3'h1, i[1] ? v : v | 8'h80);
      kw(3'h1, 8'h00);
      rd(3'h1, 8'h00);
      rd(3'h0, 8'h00);
      $display("watchdog %0d done", i);
    end
    // interval overflow through the divide-by-64 tap
    kw(3'h1, 8'h21);
    kw(3'h0, 8'hFE);
    wait_ev(0);
    repeat (2) @(posedge sys_clk_in);
    $display("divider done");
    chk("counts", cnt[0] + cnt[1] + cnt[2], 8'h04);
    end_of_test();
  end
endmodule : wdt_timer_tb
